// ---- verilog/hbgs_sequencer.sv ----
// Gate sequencer for a time-delayed hysteretic buck regulator.
// Assumes comparator results arrive as asynchronous digital levels.
//
// Overview of operation
// (R1) Precharge: low side on, high off
// (R2) Feedback low keeps high side on
// (R3) Feedback high: high off after delay
// (R4) Low side waits dead interval after high
// (R5) Dead interval 140 ns, never both on
// (R6) Feedback low: low off, then high on
// (R7) 20 us high on forces 1 us refresh
// (R8) Disable input low means normal running
// (R9) Disable high: high off, low on
// (R10) Dimming signal between 120 Hz and 5 kHz
// (R11) Disable off time above ten high-times
// (R12) Supply low: lockout, both gates off
// (R13) Filter feedback against spurious toggles
// (R14) Low side on 320 ns after rise
// (R15) Lockout re-entered only below turn-off level
// (R16) Inputs synchronized, delays by cycle counters

`timescale 1ns/10ps

module hbgs_sequencer (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // Comparator and control levels (asynchronous)
    input  wire logic current_sense_feedback_in,
    input  wire logic output_disable_input_in,
    input  wire logic supply_above_turn_on_in,
    input  wire logic supply_above_turn_off_in,
    // Gate commands
    output wire logic high_side_gate_out,
    output wire logic low_side_gate_out,
    // Status
    output wire logic undervoltage_lockout_state_out
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        hbgs_pkg::hbgs_state_e st;
        logic [11:0]           cnt;
        logic [11:0]           wd;
        logic [1:0]            fb_sync;
        logic [1:0]            dis_sync;
        logic [1:0]            on_sync;
        logic [1:0]            off_sync;
        logic [3:0]            flt_cnt;
        logic                  fb_filt;
        logic                  ho;
        logic                  lo;
    } hbgs_regs_s;

    hbgs_regs_s            s;
    hbgs_regs_s            next_s;
    hbgs_pkg::hbgs_state_e next_st;

    // ------------------------------------------------------------------
    // Gate decode per state
    // ------------------------------------------------------------------
    function automatic logic hbgs_ho_of(input hbgs_pkg::hbgs_state_e st);
        hbgs_ho_of = (st == hbgs_pkg::ST_HI_ON) ||
                     (st == hbgs_pkg::ST_HI_OFF_WAIT);
    endfunction

    function automatic logic hbgs_lo_of(input hbgs_pkg::hbgs_state_e st);
        hbgs_lo_of = (st == hbgs_pkg::ST_PRECHARGE) ||
                     (st == hbgs_pkg::ST_LO_ON) ||
                     (st == hbgs_pkg::ST_LO_OFF_WAIT) ||
                     (st == hbgs_pkg::ST_WD_REFRESH) ||
                     (st == hbgs_pkg::ST_DISABLED);
    endfunction

    // Synchronized levels (second stage only)
    logic fb_s;
    logic dis_s;
    logic on_s;
    logic off_s;

    assign fb_s  = s.fb_sync[1];
    assign dis_s = s.dis_sync[1];
    assign on_s  = s.on_sync[1];
    assign off_s = s.off_sync[1];

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_st = s.st;
        next_s.cnt = s.cnt + 12'h0001;

        // Two-stage synchronizers
        next_s.fb_sync  = {s.fb_sync[0],  current_sense_feedback_in}; // R16
        next_s.dis_sync = {s.dis_sync[0], output_disable_input_in};
        next_s.on_sync  = {s.on_sync[0],  supply_above_turn_on_in};
        next_s.off_sync = {s.off_sync[0], supply_above_turn_off_in};

        // Feedback must hold a new level before it is accepted
        if (fb_s != s.fb_filt) begin
            if (s.flt_cnt == hbgs_pkg::FILT_CYC - 4'h1) begin
                next_s.fb_filt = fb_s; // R13
                next_s.flt_cnt = 4'h0;
            end else begin
                next_s.flt_cnt = s.flt_cnt + 4'h1;
            end
        end else begin
            next_s.flt_cnt = 4'h0;
        end

        // Watchdog counts uninterrupted high-side on time
        if ((s.st == hbgs_pkg::ST_HI_ON) && !s.fb_filt) begin
            next_s.wd = s.wd + 12'h0001; // R7
        end else begin
            next_s.wd = 12'h0000;
        end

        case (s.st)
            hbgs_pkg::ST_LOCKOUT: begin
                if (on_s) begin
                    next_st = hbgs_pkg::ST_PRECHARGE; // R1
                end
            end
            hbgs_pkg::ST_PRECHARGE: begin
                if (s.cnt == hbgs_pkg::PRECHARGE_CYC - 12'h0001) begin
                    next_st = dis_s ? hbgs_pkg::ST_DISABLED
                                    : hbgs_pkg::ST_DEAD_TO_HI; // R1
                end
            end
            hbgs_pkg::ST_DEAD_TO_HI: begin
                if (s.cnt == hbgs_pkg::DEAD_CYC - 12'h0001) begin
                    next_st = hbgs_pkg::ST_HI_ON; // R6
                end
            end
            hbgs_pkg::ST_HI_ON: begin
                if (s.fb_filt) begin
                    next_st = hbgs_pkg::ST_HI_OFF_WAIT; // R3
                end else if (s.wd == hbgs_pkg::WATCHDOG_CYC - 12'h0001) begin
                    next_st = hbgs_pkg::ST_WD_DEAD; // R7
                end
            end
            hbgs_pkg::ST_HI_OFF_WAIT: begin
                if (s.cnt == hbgs_pkg::HIGH_OFF_CYC - 12'h0001) begin
                    next_st = hbgs_pkg::ST_DEAD_TO_LO; // R3 R14
                end
            end
            hbgs_pkg::ST_DEAD_TO_LO: begin
                if (s.cnt == hbgs_pkg::DEAD_CYC - 12'h0001) begin
                    next_st = hbgs_pkg::ST_LO_ON; // R4
                end
            end
            hbgs_pkg::ST_LO_ON: begin
                if (!s.fb_filt) begin
                    next_st = hbgs_pkg::ST_LO_OFF_WAIT; // R6
                end
            end
            hbgs_pkg::ST_LO_OFF_WAIT: begin
                if (s.cnt == hbgs_pkg::HIGH_OFF_CYC - 12'h0001) begin
                    next_st = hbgs_pkg::ST_DEAD_TO_HI; // R6
                end
            end
            hbgs_pkg::ST_WD_DEAD: begin
                if (s.cnt == hbgs_pkg::DEAD_CYC - 12'h0001) begin
                    next_st = hbgs_pkg::ST_WD_REFRESH; // R5
                end
            end
            hbgs_pkg::ST_WD_REFRESH: begin
                if (s.cnt == hbgs_pkg::REFRESH_CYC - 12'h0001) begin
                    next_st = hbgs_pkg::ST_DEAD_TO_HI; // R7
                end
            end
            hbgs_pkg::ST_DIS_DEAD: begin
                if (s.cnt == hbgs_pkg::DEAD_CYC - 12'h0001) begin
                    next_st = hbgs_pkg::ST_DISABLED; // R9
                end
            end
            hbgs_pkg::ST_DISABLED: begin
                if (!dis_s) begin
                    next_st = s.fb_filt ? hbgs_pkg::ST_LO_ON
                                        : hbgs_pkg::ST_DEAD_TO_HI; // R8
                end
            end
            default: begin
                next_st = hbgs_pkg::ST_LOCKOUT;
            end
        endcase

        // Disable: pass through dead interval if high side may be on
        if (dis_s) begin
            case (s.st)
                hbgs_pkg::ST_HI_ON,
                hbgs_pkg::ST_HI_OFF_WAIT,
                hbgs_pkg::ST_DEAD_TO_HI,
                hbgs_pkg::ST_DEAD_TO_LO,
                hbgs_pkg::ST_WD_DEAD: begin
                    next_st = hbgs_pkg::ST_DIS_DEAD; // R9
                end
                hbgs_pkg::ST_LO_ON,
                hbgs_pkg::ST_LO_OFF_WAIT,
                hbgs_pkg::ST_WD_REFRESH: begin
                    next_st = hbgs_pkg::ST_DISABLED; // R9
                end
                default: begin
                    next_st = next_st;
                end
            endcase
        end

        // Supply below turn-off level overrides everything
        if (!off_s) begin
            next_st = hbgs_pkg::ST_LOCKOUT; // R15
        end

        if (next_st != s.st) begin
            next_s.cnt = 12'h0000;
        end
        next_s.st = next_st;
        next_s.ho = hbgs_ho_of(next_st); // R2
        next_s.lo = hbgs_lo_of(next_st); // R12
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign high_side_gate_out             = s.ho;
    assign low_side_gate_out              = s.lo;
    assign undervoltage_lockout_state_out = (s.st == hbgs_pkg::ST_LOCKOUT);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    localparam int A_HOFF = int'(hbgs_pkg::HIGH_OFF_CYC);
    localparam int A_HOFF_HI = int'(hbgs_pkg::HIGH_OFF_CYC) + 2;

    // Cycles both gates have been low, saturating
    logic [7:0] gap_cnt;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            gap_cnt <= 8'h00;
        end else if (s.ho || s.lo) begin
            gap_cnt <= 8'h00;
        end else if (gap_cnt != 8'hff) begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    no_overlap_a: assert property (!(s.ho && s.lo)) // R5
        else $error("Both gates on together");

    dead_before_lo_a: assert property ( // R4
        $rose(s.lo) && $past(s.st) != hbgs_pkg::ST_LOCKOUT
        |-> $past(gap_cnt) >= 8'(hbgs_pkg::DEAD_CYC) - 8'h01)
        else $error("Low gate rose before dead interval");

    precharge_gates_a: assert property ( // R1
        $rose(s.st == hbgs_pkg::ST_PRECHARGE) |-> (s.lo && !s.ho) [*8])
        else $error("Precharge gates wrong");

    high_off_delay_a: assert property ( // R3
        (s.st == hbgs_pkg::ST_HI_ON && s.fb_filt && dis_s == 1'b0
         && off_s) ##1 (!dis_s && off_s) [*1]
        |-> ##[A_HOFF:A_HOFF_HI] !s.ho)
        else $error("High gate not off after delay");

    watchdog_fire_a: assert property ( // R7
        s.st == hbgs_pkg::ST_HI_ON && !s.fb_filt && !dis_s && off_s
        && s.wd == hbgs_pkg::WATCHDOG_CYC - 12'h0001
        |=> !s.ho ##[14:16] s.lo)
        else $error("Watchdog refresh missing");

    disable_gates_a: assert property ( // R9
        s.st == hbgs_pkg::ST_DISABLED |-> s.lo && !s.ho)
        else $error("Disabled gates wrong");

    lockout_gates_a: assert property ( // R12
        undervoltage_lockout_state_out |-> !s.ho && !s.lo)
        else $error("Lockout gates not low");

    lockout_entry_a: assert property (!off_s |=> // R15
        s.st == hbgs_pkg::ST_LOCKOUT)
        else $error("Lockout not entered");

    feedback_filter_a: assert property ( // R13
        $changed(s.fb_filt) |-> $past(fb_s) == s.fb_filt
        && $past(fb_s, 5) == s.fb_filt)
        else $error("Filter passed unstable level");

    high_hold_a: assert property ( // R2
        s.st == hbgs_pkg::ST_HI_ON && !s.fb_filt && !dis_s && off_s
        && s.wd != hbgs_pkg::WATCHDOG_CYC - 12'h0001 |=> s.ho)
        else $error("High gate dropped while on");

    regulate_c: cover property ($rose(s.lo) ##[1:200] $rose(s.ho));
    refresh_c: cover property ($rose(s.st == hbgs_pkg::ST_WD_REFRESH));
    dim_c: cover property ($rose(s.st == hbgs_pkg::ST_DISABLED));
    relock_c: cover property ($rose(undervoltage_lockout_state_out));

endmodule

// ---- shared/hbgs_pkg.sv ----
// Constants, states and timing for the buck gate sequencer.
// Assumes a 100 MHz system clock; all delays become cycle counts here.

package hbgs_pkg;

    // ------------------------------------------------------------------
    // Clock and raw timing figures
    // ------------------------------------------------------------------
    localparam int CLK_MHZ         = 100;
    localparam int DEAD_NS         = 140;
    localparam int HIGH_OFF_NS     = 180;
    localparam int HIGH_ON_NS      = 320;
    localparam int FILT_NS         = 50;
    localparam int WATCHDOG_US     = 20;
    localparam int REFRESH_US      = 1;
    localparam int PRECHARGE_US    = 10;
    localparam int SYNC_STAGES     = 2;

    // ------------------------------------------------------------------
    // Derived cycle counts (rounded up, at least one cycle)
    // ------------------------------------------------------------------
    localparam logic [11:0] DEAD_CYC =
        12'((DEAD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0]  FILT_CYC =
        4'((FILT_NS * CLK_MHZ + 999) / 1000);
    // Sync and filter latency are taken out of the edge delay
    localparam logic [11:0] HIGH_OFF_CYC =
        12'((HIGH_OFF_NS * CLK_MHZ + 999) / 1000
            - (FILT_NS * CLK_MHZ + 999) / 1000 - SYNC_STAGES);
    localparam logic [11:0] HIGH_ON_CYC =
        12'((HIGH_ON_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] WATCHDOG_CYC   = 12'(WATCHDOG_US * CLK_MHZ);
    localparam logic [11:0] REFRESH_CYC    = 12'(REFRESH_US * CLK_MHZ);
    localparam logic [11:0] PRECHARGE_CYC  = 12'(PRECHARGE_US * CLK_MHZ);

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_LOCKOUT,
        ST_PRECHARGE,
        ST_DEAD_TO_HI,
        ST_HI_ON,
        ST_HI_OFF_WAIT,
        ST_DEAD_TO_LO,
        ST_LO_ON,
        ST_LO_OFF_WAIT,
        ST_WD_DEAD,
        ST_WD_REFRESH,
        ST_DIS_DEAD,
        ST_DISABLED
    } hbgs_state_e;

endpackage

// ---- bench/hbgs_bridge_model.sv ----
// Behavioural half-bridge and current-sense loop for the sequencer.
// Assumes the bench shares its clock and selects the feedback mode.

`timescale 1ns/10ps

module hbgs_bridge_model (
    // Clock
    input  wire logic       clk_in,
    // Gate commands and feedback mode
    input  wire logic       high_side_gate_in,
    input  wire logic       low_side_gate_in,
    input  wire logic [1:0] mode_in,
    // Comparator result
    output wire logic       current_sense_feedback_out
);
    // ------------------------------------------------------------------
    // Inductor current ramp, clamped
    // ------------------------------------------------------------------
    int cur = 0;

    always @(posedge clk_in) begin
        if (high_side_gate_in && cur < 400) begin
            cur <= cur + 3;
        end else if (low_side_gate_in && cur > 1) begin
            cur <= cur - 2;
        end
    end

    // Mode 1 open load, mode 2 stuck above threshold
    assign current_sense_feedback_out = (mode_in == 2'h2) ||
        (mode_in == 2'h0 && cur >= 200);
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the buck gate sequencer.
// Assumes the bridge model closes the current loop on the gates.

`timescale 1ns/10ps

module tb;
    // ------------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------------
    localparam int PRE  = int'(hbgs_pkg::PRECHARGE_CYC);
    localparam int DEAD = int'(hbgs_pkg::DEAD_CYC);
    localparam int WD   = int'(hbgs_pkg::WATCHDOG_CYC);
    localparam int REF  = int'(hbgs_pkg::REFRESH_CYC);
    localparam int HON  = int'(hbgs_pkg::HIGH_ON_CYC);
    localparam logic [31:0] ONE  = 32'h0000_0001;
    localparam logic [31:0] ZERO = 32'h0000_0000;

    logic       clk      = 1'b0;
    logic       rst      = 1'b1;
    logic       dis      = 1'b0;
    logic       v_on     = 1'b0;
    logic       v_off    = 1'b0;
    logic [1:0] mode     = 2'h0;
    wire logic  fb;
    wire logic  hi;
    wire logic  lo;
    wire logic  undervoltage_lockout_state;
    int         errors   = 0;
    int         compares = 0;
    int         cycles   = 0;
    int         overlap  = 0;

    always #5 clk = ~clk;

    hbgs_sequencer hbgs_sequencer_i (
        .clk_in                         (clk),
        .sys_rst_in                     (rst),
        .current_sense_feedback_in      (fb),
        .output_disable_input_in        (dis),
        .supply_above_turn_on_in        (v_on),
        .supply_above_turn_off_in       (v_off),
        .high_side_gate_out             (hi),
        .low_side_gate_out              (lo),
        .undervoltage_lockout_state_out (undervoltage_lockout_state)
    );

    hbgs_bridge_model hbgs_bridge_model_i (
        .clk_in                     (clk),
        .high_side_gate_in          (hi),
        .low_side_gate_in           (lo),
        .mode_in                    (mode),
        .current_sense_feedback_out (fb)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (hi === 1'b1 && lo === 1'b1) begin
            overlap <= overlap + 1;
        end
        if (cycles == 80000) begin
            errors = errors + 1;
            $display("MISMATCH timeout expected finish seen hang");
            close_out();
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, seen);
        end
    endtask

    task automatic in_range(input string name, input int n,
                            input int a, input int b);
        check(name, (n >= a && n <= b) ? ONE : ZERO, ONE);
    endtask

    // Wait until one gate reaches a level, counting cycles
    task automatic wait_gate(input bit low_side, input logic val,
                             input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((low_side ? lo : hi) !== val && n < lim);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_startup();
        int n;
        check("lockout", {31'h0000_0000, undervoltage_lockout_state}, ONE);
        check("gates", {30'h0000_0000, hi, lo}, ZERO);
        @(posedge clk);
        v_on <= 1'b1;
        v_off <= 1'b1;
        wait_gate(1, 1'b1, 20, n);
        check("precharge high", {31'h0000_0000, hi}, ZERO);
        wait_gate(1, 1'b0, PRE + 100, n);
        in_range("precharge", n, PRE - 2, PRE + 2);
        wait_gate(0, 1'b1, 40, n);
        in_range("first dead", n, DEAD, DEAD + 1);
        $display("test startup done");
    endtask

    task automatic t_edges();
        int n;
        int m;
        @(posedge clk);
        mode <= 2'h2;
        wait_gate(0, 1'b0, 40, n);
        in_range("high off delay", n, 16, 21);
        wait_gate(1, 1'b1, 40, m);
        in_range("low on delay", n + m, 30, 35);
        @(posedge clk);
        mode <= 2'h1;
        wait_gate(1, 1'b0, 40, n);
        in_range("low off delay", n, 16, 21);
        wait_gate(0, 1'b1, 40, m);
        in_range("high on dead", m, DEAD, DEAD + 1);
        in_range("high on delay", n + m, HON, HON + 3);
        wait_gate(0, 1'b0, WD + 50, n);
        in_range("watchdog", n, WD - 3, WD + 3);
        wait_gate(1, 1'b1, 40, m);
        in_range("watchdog dead", m, DEAD, DEAD + 1);
        wait_gate(1, 1'b0, REF + 50, n);
        in_range("refresh", n, REF - 3, REF + 3);
        wait_gate(0, 1'b1, 40, m);
        in_range("resume dead", m, DEAD, DEAD + 1);
        @(posedge clk);
        mode <= 2'h2;
        repeat (3) @(posedge clk);
        mode <= 2'h1;
        wait_gate(0, 1'b0, 40, n);
        check("glitch", n, 32'h0000_0028);
        @(posedge clk);
        mode <= 2'h0;
        $display("test edges done");
    endtask

    // One dimming period at 5 kHz, off time about equal to the on time
    task automatic t_disable();
        int   n;
        int   rises;
        logic prev;
        @(posedge clk);
        dis <= 1'b1;
        repeat (40) @(posedge clk);
        n = 0;
        repeat (10000) begin
            @(posedge clk);
            #1;
            if (hi !== 1'b0 || lo !== 1'b1) n++;
        end
        check("disabled", n, ZERO);
        @(posedge clk);
        dis <= 1'b0;
        rises = 0;
        prev = hi;
        repeat (10000) begin
            @(posedge clk);
            #1;
            if (hi === 1'b1 && prev === 1'b0) rises++;
            prev = hi;
        end
        in_range("regulating", rises, 20, 10000);
        check("overlap", overlap, ZERO);
        $display("test disable done");
    endtask

    task automatic t_supply();
        int n;
        @(posedge clk);
        v_on <= 1'b0;
        repeat (50) @(posedge clk);
        #1;
        check("hysteresis", {31'h0000_0000, undervoltage_lockout_state}, ZERO);
        @(posedge clk);
        v_off <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check("lockout again", {29'h0000_0000, undervoltage_lockout_state, hi, lo},
              32'h0000_0004);
        @(posedge clk);
        v_on <= 1'b1;
        v_off <= 1'b1;
        wait_gate(1, 1'b1, 20, n);
        check("restart", {30'h0000_0000, undervoltage_lockout_state, hi}, ZERO);
        $display("test supply done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_startup();
        t_edges();
        t_disable();
        t_supply();
        close_out();
    end
endmodule
